// file: design/svd_ctrl.sv
// Supply voltage detect control: registers, qualification, interrupt
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module svd_ctrl
    import svd_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC      // Reference settle
) (
    input  wire logic              clock,         // System clock
    input  wire logic              nrst,          // Async reset, low
    input  wire logic              ce,            // Clock enable
    input  wire svd_bus_s          bus,           // Register request
    output logic [DATA_W-1:0]      rdata,         // Read data
    input  wire svd_analog_s       analog,        // Async analog levels
    input  wire logic              sleep_mode,    // Device is asleep
    output logic                   detector_power,// Analog enable
    output logic                   trip_dir,      // Direction to analog
    output logic [LVL_W-1:0]       trip_level,    // Divider tap select
    output logic                   ext_trip_sel,  // External input mux
    output logic                   irq,           // Interrupt level
    output logic                   wake_req       // Wake-up request
);

    // ************************************************************
    // Checks
    // ************************************************************
    if (SETTLE_CYCLES < 3) begin : g_bad_settle
        $error("svd_ctrl: SETTLE_CYCLES must be at least 3");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [DATA_W-1:0] ctrl_reg;                  // Writable control bits
    logic [IRQ_W-1:0]  stat_reg;                  // Sticky event status
    logic [IRQ_W-1:0]  irq_en_reg;                // Interrupt enable
    logic              ext_sel_reg;               // External mux select
    logic              irq_reg;                   // Interrupt output
    logic              wake_reg;                  // Wake request output
    logic [DATA_W-1:0] rdata_reg;                 // Read data output
    logic [1:0]        sync_q;                    // Synchronised levels
    logic              cmp_s;                     // Synced comparator
    logic              bg_s;                      // Synced bandgap
    logic              settled;                   // Timer finished
    logic              ref_stable;                // Qualified reference
    logic              trip_cond;                 // Crossing in direction
    logic              evt_set;                   // Qualified event
    logic              wr_ctrl;                   // Control write
    logic              wr_clr;                    // Status clear write
    logic              wr_en;                     // Enable write
    logic [DATA_W-1:0] ctrl_view;                 // Control with RO bits
    logic [DATA_W-1:0] rd_mux;                    // Selected read value
    logic [DATA_W-1:0] ctrl_next;                 // Next control value
    logic [IRQ_W-1:0]  stat_next;                 // Next status value
    logic [IRQ_W-1:0]  evt_vec;                   // Events by bit

    // Widen a status-sized vector into the data width
    function automatic logic [DATA_W-1:0] widen(input logic [IRQ_W-1:0] v);
        widen = {{(DATA_W-IRQ_W){1'b0}}, v};
    endfunction

    // ************************************************************
    // Analog inputs
    // ************************************************************
    // Both levels are asynchronous to the clock
    svd_sync #(
        .WIDTH   (2)
    ) u_sync (
        .clock   (clock),
        .nrst    (nrst),
        .ce      (ce),
        .d_async ({analog.cmp, analog.bandgap}),
        .q_sync  (sync_q)
    );
    assign cmp_s = sync_q[1];
    assign bg_s  = sync_q[0];

    // Settling timer restarts on every enable
    svd_settle #(
        .CYCLES  (SETTLE_CYCLES)
    ) u_settle (
        .clock   (clock),
        .nrst    (nrst),
        .ce      (ce),
        .run     (ctrl_reg[BIT_EN]),
        .done    (settled)
    );
    // Stable only from internal state, so bus writes cannot force it
    assign ref_stable = settled && bg_s;

    // ************************************************************
    // Event qualification
    // ************************************************************
    // Comparator is high while supply sits at or above the trip level
    assign trip_cond = ctrl_reg[BIT_DIR] ? cmp_s : !cmp_s;
    // Level sensitive: a crossing still held when settling ends sets the event then
    assign evt_set = ctrl_reg[BIT_EN] && ref_stable && trip_cond;
    assign evt_vec = IRQ_W'(evt_set) << BIT_EVT;

    // ************************************************************
    // Register decode
    // ************************************************************
    assign wr_ctrl = bus.wr && bus.addr == ADDR_CTRL;
    assign wr_clr  = bus.wr && bus.addr == ADDR_IRQ_CLR;
    assign wr_en   = bus.wr && bus.addr == ADDR_IRQ_EN;

    // Read-only bits are masked off the write and never stored
    assign ctrl_next = wr_ctrl ?
        (bus.wdata & ~(DATA_W'(1) << BIT_BGST) & ~(DATA_W'(1) << BIT_REFST))
        : ctrl_reg;

    // Set wins over a clear arriving in the same cycle
    assign stat_next = (stat_reg & ~(wr_clr ? bus.wdata[IRQ_W-1:0] : '0))
                       | evt_vec;

    // Control view with live status bits
    assign ctrl_view = ctrl_reg
                     | (DATA_W'(bg_s) << BIT_BGST)
                     | (DATA_W'(ref_stable) << BIT_REFST);

    // Read select; clear register and idle reads return zero
    assign rd_mux = !bus.rd                ? '0 :
                    bus.addr == ADDR_CTRL     ? ctrl_view :
                    bus.addr == ADDR_IRQ_STAT ? widen(stat_reg) :
                    bus.addr == ADDR_IRQ_EN   ? widen(irq_en_reg) : '0;

    // ************************************************************
    // Registers
    // ************************************************************
    // Control register and derived mux select
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg    <= CTRL_RESET;
            ext_sel_reg <= 1'b0;
        end else if (ce) begin
            ctrl_reg    <= ctrl_next;
            ext_sel_reg <= ctrl_next[LVL_LSB +: LVL_W] == LVL_EXT;
        end
    end

    // Interrupt status and enable
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stat_reg   <= IRQ_RESET;
            irq_en_reg <= IRQ_RESET;
        end else if (ce) begin
            stat_reg   <= stat_next;
            irq_en_reg <= wr_en ? bus.wdata[IRQ_W-1:0] : irq_en_reg;
        end
    end

    // Outputs; irq follows status one cycle later by design
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_reg   <= 1'b0;
            wake_reg  <= 1'b0;
            rdata_reg <= '0;
        end else if (ce) begin
            irq_reg   <= |(stat_reg & irq_en_reg);
            wake_reg  <= sleep_mode && evt_set;
            rdata_reg <= rd_mux;
        end
    end

    assign detector_power = ctrl_reg[BIT_EN];
    assign trip_dir       = ctrl_reg[BIT_DIR];
    assign trip_level     = ctrl_reg[LVL_LSB +: LVL_W];
    assign ext_trip_sel   = ext_sel_reg;
    assign irq            = irq_reg;
    assign wake_req       = wake_reg;
    assign rdata          = rdata_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    // Each antecedent but those of a_settle_early and a_settle_reach carries ce, since a frozen cycle says nothing
    // about the next edge. The age counter below is kept apart from
    // the settle timer on purpose, so that a miscount in either one
    // shows up as a disagreement between the two.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    // Cycles since the detector was last switched on, saturating
    localparam int AGE_W = $clog2(SETTLE_CYCLES + 1);       // Age width
    localparam logic [AGE_W-1:0] AGE_MAX = AGE_W'(SETTLE_CYCLES); // Cap
    logic [AGE_W-1:0] age_reg;                    // Enabled age
    logic [AGE_W-1:0] age_next;                   // Next age

    // Cleared while off; stops at the cap so it never wraps
    assign age_next = !ctrl_reg[BIT_EN] ? '0 :
                      age_reg == AGE_MAX ? age_reg : age_reg + AGE_W'(1);

    // Helper register, frozen with the rest of the block
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            age_reg <= '0;
        end else if (ce) begin
            age_reg <= age_next;
        end
    end

    // Enable rising, then the reference must stay low for two cycles
    sequence s_enable_rise;
        ce && $rose(ctrl_reg[BIT_EN]);
    endsequence
    sequence s_hold_low;
        !ref_stable [*2];
    endsequence
    // Enable falling; the settle wait must start over
    sequence s_enable_fall;
        ce && $fell(ctrl_reg[BIT_EN]);
    endsequence
    // A clear of the event bit with no live event behind it
    sequence s_clear_quiet;
        ce && wr_clr && bus.wdata[BIT_EVT] && !evt_set;
    endsequence

    a_settle_hold: assert property (s_enable_rise |-> s_hold_low)
        else $error("reference stable rose too soon after enable");

    a_settle_redo: assert property (s_enable_fall |=> !ref_stable)
        else $error("reference stayed stable after disable");

    a_settle_early: assert property (
        ref_stable |-> age_reg == AGE_MAX)
        else $error("reference stable before settle time");

    a_settle_reach: assert property (
        ctrl_reg[BIT_EN] && age_reg == AGE_MAX |-> ref_stable == bg_s)
        else $error("reference not stable after settle time");

    a_refst_nowrite: assert property (
        ce && wr_ctrl && bus.wdata[BIT_REFST] && !ctrl_reg[BIT_EN]
        |=> !ref_stable)
        else $error("write forced reference stable flag");

    a_no_early_evt: assert property (
        ce && !stat_reg[BIT_EVT] && !wr_clr && !ref_stable
        |=> !stat_reg[BIT_EVT])
        else $error("event flag set before reference stable");

    a_rise_evt: assert property (
        ce && ctrl_reg[BIT_EN] && ref_stable && ctrl_reg[BIT_DIR] && cmp_s
        |=> stat_reg[BIT_EVT])
        else $error("rising trip did not set event flag");

    a_fall_evt: assert property (
        ce && ctrl_reg[BIT_EN] && ref_stable && !ctrl_reg[BIT_DIR] && !cmp_s
        |=> stat_reg[BIT_EVT])
        else $error("falling trip did not set event flag");

    a_enable_write: assert property (
        ce && wr_ctrl |=> detector_power == $past(bus.wdata[BIT_EN]))
        else $error("detector enable did not follow write");

    a_ext_select: assert property (
        ce && wr_ctrl
        |=> ext_trip_sel == ($past(bus.wdata[LVL_LSB +: LVL_W]) == LVL_EXT))
        else $error("external trip select mismatch");

    a_bg_read: assert property (
        ce && bus.rd && bus.addr == ADDR_CTRL
        |=> rdata[BIT_BGST] == $past(bg_s))
        else $error("bandgap flag read wrong");

    a_refst_read: assert property (
        ce && bus.rd && bus.addr == ADDR_CTRL
        |=> rdata[BIT_REFST] == $past(ref_stable))
        else $error("reference stable flag read wrong");

    a_wake_sleep: assert property (
        ce && sleep_mode && evt_set |=> wake_req && stat_reg[BIT_EVT])
        else $error("sleep trip gave no wake request");

    a_wake_quiet: assert property (
        ce && !sleep_mode |=> !wake_req)
        else $error("wake request while awake");

    a_clear_event: assert property (
        s_clear_quiet |=> !stat_reg[BIT_EVT])
        else $error("event flag survived a quiet clear");

    a_irq_on: assert property (
        ce && |(stat_reg & irq_en_reg) |=> irq)
        else $error("enabled event gave no interrupt");

    a_irq_off: assert property (
        ce && !(|(stat_reg & irq_en_reg)) |=> !irq)
        else $error("interrupt without enabled event");

    a_sync_delay: assert property (
        ce && $past(ce) && $past(ce, 2) && $past(nrst)
        && $past(nrst, 2) |-> cmp_s == $past(analog.cmp, 2))
        else $error("comparator not delayed two cycles");

endmodule
`default_nettype wire

// file: design/svd_pkg.sv
// Shared constants and types of the supply voltage detect control block
package svd_pkg;

    // ************************************************************
    // Register bus
    // ************************************************************
    localparam int ADDR_W = 2;                    // Address width
    localparam int DATA_W = 8;                    // Data width

    // Register indices
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 2'h0; // Control
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 2'h1; // Sticky status
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 2'h2; // Write-1 clear
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 2'h3; // Interrupt enable

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int BIT_DIR    = 7;                // Trip direction select
    localparam int BIT_BGST   = 6;                // Bandgap stable, RO
    localparam int BIT_REFST  = 5;                // Reference stable, RO
    localparam int BIT_EN     = 4;                // Detector enable
    localparam int LVL_LSB    = 0;                // Trip level low bit
    localparam int LVL_W      = 4;                // Trip level width
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00; // Detector off
    localparam logic [LVL_W-1:0]  LVL_EXT    = 4'hF;  // External input
    localparam logic [LVL_W-1:0]  LVL_MAX    = 4'hE;  // Highest internal

    // Interrupt status layout: one event bit
    localparam int IRQ_W       = 1;               // Number of events
    localparam int BIT_EVT     = 0;               // Voltage event bit
    localparam logic [IRQ_W-1:0] IRQ_RESET = 1'h0; // Nothing pending

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;            // 100 MHz system clock
    localparam int SETTLE_NS     = 20000;         // Reference settle time
    // Least time, rounded up to whole cycles
    localparam int SETTLE_CYC =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;                  // Register index
        logic [DATA_W-1:0] wdata;                 // Write data
        logic              wr;                    // Write strobe
        logic              rd;                    // Read strobe
    } svd_bus_s;

    typedef struct packed {
        logic             cmp;                    // Supply above trip
        logic             bandgap;                // Bandgap ready level
    } svd_analog_s;

endpackage

// file: design/svd_settle.sv
// Settling timer that qualifies the reference after each enable
`timescale 1ns/1ps
`default_nettype none
module svd_settle
    import svd_pkg::*;
#(
    parameter int CYCLES = SETTLE_CYC             // Settle length
) (
    input  wire logic clock,                      // System clock
    input  wire logic nrst,                       // Async reset, low
    input  wire logic ce,                         // Clock enable
    input  wire logic run,                        // Detector enabled
    output logic      done                        // Settled level
);

    localparam int CW = $clog2(CYCLES + 1);       // Counter width
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1); // Final count

    // ************************************************************
    // Checks
    // ************************************************************
    if (CYCLES < 3) begin : g_bad_cycles
        $error("svd_settle: CYCLES must be at least 3");
    end

    logic [CW-1:0] cnt_reg;                       // Cycles since enable
    logic [CW-1:0] cnt_next;                      // Next count
    logic          done_next;                     // Next settled state

    // Any disable restarts the wait, so each enable settles anew
    assign cnt_next  = (!run || done) ? '0 : cnt_reg + CW'(1);
    assign done_next = run && (done || cnt_reg == LAST);

    // Count and flag
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
            done    <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            done    <= done_next;
        end
    end

endmodule
`default_nettype wire

// file: design/svd_sync.sv
// Two-stage level synchroniser for asynchronous analog status levels
`timescale 1ns/1ps
`default_nettype none
module svd_sync
    import svd_pkg::*;
#(
    parameter int WIDTH = 2                       // Number of levels
) (
    input  wire logic             clock,          // System clock
    input  wire logic             nrst,           // Async reset, low
    input  wire logic             ce,             // Clock enable
    input  wire logic [WIDTH-1:0] d_async,        // Async levels in
    output logic      [WIDTH-1:0] q_sync          // Synchronised out
);

    // ************************************************************
    // Checks
    // ************************************************************
    if (WIDTH < 1) begin : g_bad_width
        $error("svd_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta_reg;                   // First stage only

    // First stage feeds the second stage and nothing else
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '0;
            q_sync   <= '0;
        end else if (ce) begin
            meta_reg <= d_async;
            q_sync   <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// file: tb/svd_ctrl_bench.sv
// Self-checking testbench of the supply voltage detect control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("ERROR %s expected %h seen %h", nm, exp, got); \
    end end
module svd_ctrl_bench
    import svd_pkg::*;
;
    // ************************************************************
    // Stimulus and observation signals
    // ************************************************************
    localparam int SETTLE = 4;                    // Short settle for sim
    logic              clock;                     // System clock
    logic              nrst;                      // Async reset, low
    logic              ce;                        // Clock enable
    svd_bus_s          bus;                       // Register request
    logic [DATA_W-1:0] rdata;                     // Read data
    svd_analog_s       analog;                    // Analog levels
    logic              sleep_mode;                // Device asleep
    logic              detector_power;            // Analog enable
    logic              trip_dir;                  // Direction out
    logic [LVL_W-1:0]  trip_level;                // Level out
    logic              ext_trip_sel;              // External mux
    logic              irq;                       // Interrupt level
    logic              wake_req;                  // Wake request
    int                miscompares;               // Mismatch count
    int                checks;                    // Comparison count

    svd_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (
        .clock          (clock),
        .nrst           (nrst),
        .ce             (ce),
        .bus            (bus),
        .rdata          (rdata),
        .analog         (analog),
        .sleep_mode     (sleep_mode),
        .detector_power (detector_power),
        .trip_dir       (trip_dir),
        .trip_level     (trip_level),
        .ext_trip_sel   (ext_trip_sel),
        .irq            (irq),
        .wake_req       (wake_req)
    );

    // ************************************************************
    // Clock, time-zero values and watchdog
    // ************************************************************
    // Free-running 100 MHz clock
    always #5 clock = ~clock;

    // Whole run is well under a few hundred cycles; the margin is ample
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        results();
    end

    // ************************************************************
    // Bus and wait helpers
    // ************************************************************
    // One-cycle write strobe beside address and data
    task automatic bus_write(input logic [ADDR_W-1:0] a,
                             input logic [DATA_W-1:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    // Read strobe for one cycle; data are taken in the following cycle
    task automatic bus_read(input logic [ADDR_W-1:0] a,
                            output logic [DATA_W-1:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Read and compare in one go
    task automatic rd_chk(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] e, input string nm);
        logic [DATA_W-1:0] d;
        bus_read(a, d);
        `CHK(nm, e, d)
    endtask

    // Bounded poll of the reference stable bit; gives up quietly
    task automatic wait_ref_stable();
        logic [DATA_W-1:0] d;
        d = 8'h00;
        for (int n = 0; n < 20 && d[BIT_REFST] !== 1'b1; n++) begin
            bus_read(ADDR_CTRL, d);
        end
    endtask

    // Bounded wait on the interrupt line
    task automatic wait_irq();
        for (int n = 0; n < 20 && irq !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset state and field write-back, read-only bits ignored
    task automatic test_fields();
        rd_chk(ADDR_CTRL, CTRL_RESET, "ctrl reset");
        `CHK("power at reset", 1'b0, detector_power)
        rd_chk(ADDR_CTRL, 8'h00, "ctrl reset again");
        bus_write(ADDR_CTRL, 8'h6E);
        rd_chk(ADDR_CTRL, 8'h0E, "ro bits ignored");
        `CHK("max level", LVL_MAX, trip_level)
        `CHK("no ext at max", 1'b0, ext_trip_sel)
        bus_write(ADDR_CTRL, 8'h8F);
        #1;
        `CHK("ext selected", 1'b1, ext_trip_sel)
        `CHK("dir rising", 1'b1, trip_dir)
        bus_write(ADDR_CTRL, 8'h00);
    endtask

    // Falling event: held off until the reference settles
    task automatic test_falling();
        analog <= '{cmp: 1'b0, bandgap: 1'b0};
        bus_write(ADDR_IRQ_EN, 8'h01);
        // Reference bit set in the write must not stick
        bus_write(ADDR_CTRL, 8'h35);
        #1;
        `CHK("power on", 1'b1, detector_power)
        rd_chk(ADDR_CTRL, 8'h15, "ref low after enable");
        // Without a ready bandgap the reference must never qualify
        repeat (SETTLE + 8) @(posedge clock);
        rd_chk(ADDR_CTRL, 8'h15, "bandgap not ready");
        rd_chk(ADDR_IRQ_STAT, 8'h00, "event discarded");
        analog.bandgap <= 1'b1;
        wait_ref_stable();
        rd_chk(ADDR_CTRL, 8'h75, "both stable");
        wait_irq();
        `CHK("irq falling", 1'b1, irq)
        rd_chk(ADDR_IRQ_STAT, 8'h01, "status falling");
        rd_chk(ADDR_IRQ_CLR, 8'h00, "clear reads zero");
        // Condition must end first, since a live event wins over a clear
        analog.cmp <= 1'b1;
        repeat (4) @(posedge clock);
        bus_write(ADDR_IRQ_CLR, 8'h01);
        rd_chk(ADDR_IRQ_STAT, 8'h00, "status cleared");
        `CHK("irq dropped", 1'b0, irq)
    endtask

    // Rising event through the synchroniser, in sleep, then disable
    task automatic test_rising();
        analog <= '{cmp: 1'b0, bandgap: 1'b1};
        bus_write(ADDR_CTRL, 8'h00);
        bus_write(ADDR_CTRL, 8'h95);
        rd_chk(ADDR_CTRL, 8'hD5, "ref low on re-enable");
        wait_ref_stable();
        repeat (6) @(posedge clock);
        rd_chk(ADDR_IRQ_STAT, 8'h00, "no rising event");
        sleep_mode <= 1'b1;
        @(posedge clock);
        analog.cmp <= 1'b1;
        @(posedge clock);
        #1;
        `CHK("sync delay", 1'b0, irq)
        wait_irq();
        `CHK("irq rising", 1'b1, irq)
        `CHK("wake request", 1'b1, wake_req)
        sleep_mode <= 1'b0;
        bus_write(ADDR_CTRL, 8'h85);
        #1;
        `CHK("power off", 1'b0, detector_power)
        rd_chk(ADDR_CTRL, 8'hC5, "ref low when off");
    endtask

    // Map corners, frozen clock enable, then a reset in mid-run
    task automatic test_map();
        rd_chk(ADDR_IRQ_EN, 8'h01, "enable reads back");
        bus_write(ADDR_IRQ_STAT, 8'h00);
        rd_chk(ADDR_IRQ_STAT, 8'h01, "status write ignored");
        @(posedge clock);
        #1;
        `CHK("read data one cycle", 8'h00, rdata)
        // With ce low neither the enable nor the clear may be taken
        @(posedge clock);
        ce <= 1'b0;
        bus_write(ADDR_CTRL, 8'h10);
        bus_write(ADDR_IRQ_CLR, 8'h01);
        ce <= 1'b1;
        #1;
        `CHK("frozen enable", 1'b0, detector_power)
        `CHK("frozen clear", 1'b1, irq)
        `CHK("no wake awake", 1'b0, wake_req)
        // Reset while enabled must leave the detector off
        bus_write(ADDR_CTRL, 8'h9E);
        #2 nrst = 1'b0;
        @(posedge clock);
        #2 nrst = 1'b1;
        `CHK("irq after reset", 1'b0, irq)
        `CHK("dir after reset", 1'b0, trip_dir)
        rd_chk(ADDR_CTRL, CTRL_RESET, "ctrl after reset");
        `CHK("power after reset", 1'b0, detector_power)
    endtask

    // ************************************************************
    // Main sequence and verdict
    // ************************************************************
    // Prints counts and verdict, then ends the run
    task automatic results();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reset for 8 cycles, released away from the edge
    initial begin
        clock = 1'b0;
        nrst = 1'b0;
        ce = 1'b1;
        bus = '0;
        analog = '0;
        sleep_mode = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (8) @(posedge clock);
        #2 nrst = 1'b1;
        test_fields();
        test_falling();
        test_rising();
        test_map();
        results();
    end
endmodule
`default_nettype wire
